// ### design/flash_bus_controller.sv
/*
 Host-side controller for a four-lane flash array: read, write and reset cycles.
 Assumes one requester that waits for reqReady before a new request.
*/
`timescale 1ns/1ns
module flash_bus_controller #(
   parameter int SELECT_ACCESS_CYCLES = flash_bus_pkg::SELECT_ACCESS_CYCLES,
   parameter int ADDRESS_ACCESS_CYCLES = flash_bus_pkg::ADDRESS_ACCESS_CYCLES,
   parameter int WRITE_PULSE_CYCLES = flash_bus_pkg::WRITE_PULSE_CYCLES,
   parameter int RESET_PULSE_CYCLES = flash_bus_pkg::RESET_PULSE_CYCLES
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic reqValid,
   input wire logic reqWrite,
   input wire logic reqReset,
   input wire logic [20:0] reqAddr,
   input wire logic [3:0] reqLanes,
   input wire logic [31:0] reqData,
   output logic reqReady,
   output logic rspValid,
   output logic [31:0] rspData,
   output logic [20:0] flashAddr,
   output logic [3:0] byte_lane_select_n,
   output logic [3:0] byte_lane_write_strobe_n,
   output logic outputGate_n,
   output logic flashReset_n,
   output logic [31:0] dataOut,
   output logic dataOe,
   input wire logic [31:0] dataIn
);
   flash_pins_if pins ();

   logic [20:0] addr, next_addr;
   logic rspV, next_rspV;
   logic [31:0] rspD, next_rspD;
   logic pending, next_pending;

   // ------------------------------------------------------------
   // Request capture
   // ------------------------------------------------------------
   // Reads wait the longer of the select and address access times: lanes were deselected
   // between cycles, and the address may have changed since the last cycle.
   always_comb begin
      next_addr = addr;
      next_rspV = 1'b0;
      next_rspD = rspD;
      next_pending = pending;
      pins.start = 1'b0;
      pins.isWrite = reqWrite;
      pins.isReset = reqReset;
      pins.laneMask = reqLanes;
      pins.wrData = reqData;
      if (reqReset) begin
         pins.holdCycles = 8'(RESET_PULSE_CYCLES);
      end else if (reqWrite) begin
         pins.holdCycles = 8'(WRITE_PULSE_CYCLES);
      end else if (SELECT_ACCESS_CYCLES > ADDRESS_ACCESS_CYCLES) begin
         pins.holdCycles = 8'(SELECT_ACCESS_CYCLES);
      end else begin
         pins.holdCycles = 8'(ADDRESS_ACCESS_CYCLES);
      end
      if (reqValid && reqReady) begin
         pins.start = 1'b1;
         next_pending = 1'b1;
         if (!reqReset) begin
            next_addr = reqAddr;
         end
      end
      if (pending && pins.done) begin
         next_pending = 1'b0;
         next_rspV = 1'b1;
         next_rspD = pins.rdData;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         addr <= 21'h000000;
         rspV <= 1'b0;
         rspD <= 32'h00000000;
         pending <= 1'b0;
      end else begin
         addr <= next_addr;
         rspV <= next_rspV;
         rspD <= next_rspD;
         pending <= next_pending;
      end
   end

   flash_pin_sequencer u_seq (
      .mclk(mclk),
      .reset(reset),
      .cmd(pins.seq),
      .laneSelect_n(byte_lane_select_n),
      .laneWriteStrobe_n(byte_lane_write_strobe_n),
      .outputGate_n(outputGate_n),
      .flashReset_n(flashReset_n),
      .dataOut(dataOut),
      .dataOe(dataOe),
      .dataIn(dataIn)
   );

   assign reqReady = !pending && !pins.busy;
   assign rspValid = rspV;
   assign rspData = rspD;
   // Address is held after a cycle so an idle flash can drop into automatic sleep.
   assign flashAddr = addr;
endmodule : flash_bus_controller

// ### design/flash_bus_pkg.sv
/*
 Constants shared by the flash bus controller and its pin sequencer.
 Assumes a 25 MHz system clock and a flash array with four byte lanes.
*/
package flash_bus_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int LANES = 4;
   localparam int LANE_BITS = 8;
   localparam int DATA_BITS = 32;
   localparam int ADDR_BITS = 21;
   // Access times in ns; defaults match the slowest speed grade.
   localparam int SELECT_ACCESS_TIME_NS = 120;
   localparam int ADDRESS_ACCESS_TIME_NS = 120;
   localparam int WRITE_PULSE_NS = 50;
   localparam int RESET_PULSE_NS = 500;
   localparam int RESET_RECOVER_NS = 50;
   localparam int SELECT_ACCESS_CYCLES = (SELECT_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ADDRESS_ACCESS_CYCLES = (ADDRESS_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_PULSE_CYCLES = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESET_RECOVER_CYCLES = (RESET_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COUNT_BITS = 8;
   localparam logic [LANES-1:0] LANES_OFF = 4'hF;
endpackage : flash_bus_pkg

// ### design/flash_pin_sequencer.sv
/*
 Drives one flash bus cycle: read, write or reset pulse, then releases the pins.
 Assumes the flash data pins are resolved from dataOe by the surroundings.
*/
`timescale 1ns/1ns
module flash_pin_sequencer (
   input wire logic mclk,
   input wire logic reset,
   flash_pins_if.seq cmd,
   output logic [3:0] laneSelect_n,
   output logic [3:0] laneWriteStrobe_n,
   output logic outputGate_n,
   output logic flashReset_n,
   output logic [31:0] dataOut,
   output logic dataOe,
   input wire logic [31:0] dataIn
);
   typedef enum logic [1:0] {S_IDLE = 2'b00, S_ACTIVE = 2'b01, S_RECOVER = 2'b10} seq_state_t;
   seq_state_t state, next_state;
   logic [7:0] count, next_count;
   logic [3:0] sel, next_sel, wrs, next_wrs;
   logic gate, next_gate, rst, next_rst, oe, next_oe, done, next_done;
   logic [31:0] rdData, next_rdData, wdata, next_wdata;
   logic writeCycle, next_writeCycle;

   // ------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_count = count;
      next_sel = sel;
      next_wrs = wrs;
      next_gate = gate;
      next_rst = rst;
      next_oe = oe;
      next_done = 1'b0;
      next_rdData = rdData;
      next_wdata = wdata;
      next_writeCycle = writeCycle;
      unique case (state)
         S_IDLE: begin
            if (cmd.start) begin
               next_state = S_ACTIVE;
               next_count = cmd.holdCycles;
               next_writeCycle = cmd.isWrite;
               if (cmd.isReset) begin
                  next_rst = 1'b0;
               end else if (cmd.isWrite) begin
                  next_sel = ~cmd.laneMask;
                  next_wrs = ~cmd.laneMask;
                  next_gate = 1'b1;
                  next_oe = 1'b1;
                  next_wdata = cmd.wrData;
               end else begin
                  next_sel = ~cmd.laneMask;
                  next_wrs = flash_bus_pkg::LANES_OFF;
                  next_gate = 1'b0;
               end
            end
         end
         S_ACTIVE: begin
            if (count <= 8'h01) begin
               next_state = S_RECOVER;
               next_count = 8'(flash_bus_pkg::RESET_RECOVER_CYCLES);
               if (!writeCycle && rst) begin
                  // Sampled only after the full access wait; unselected lanes read zero.
                  for (int i = 0; i < flash_bus_pkg::LANES; i++) begin
                     next_rdData[i*8 +: 8] = sel[i] ? 8'h00 : dataIn[i*8 +: 8];
                  end
               end
               next_sel = flash_bus_pkg::LANES_OFF;
               next_wrs = flash_bus_pkg::LANES_OFF;
               next_gate = 1'b1;
               next_rst = 1'b1;
            end else begin
               next_count = count - 8'h01;
            end
         end
         S_RECOVER: begin
            // Data stays driven for the first recovery cycle to give write hold time.
            next_oe = 1'b0;
            if (count <= 8'h01) begin
               next_state = S_IDLE;
               next_done = 1'b1;
            end else begin
               next_count = count - 8'h01;
            end
         end
         default: next_state = S_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state <= S_IDLE;
         count <= 8'h00;
         sel <= 4'hF;
         wrs <= 4'hF;
         gate <= 1'b1;
         rst <= 1'b1;
         oe <= 1'b0;
         done <= 1'b0;
         rdData <= 32'h00000000;
         wdata <= 32'h00000000;
         writeCycle <= 1'b0;
      end else begin
         state <= next_state;
         count <= next_count;
         sel <= next_sel;
         wrs <= next_wrs;
         gate <= next_gate;
         rst <= next_rst;
         oe <= next_oe;
         done <= next_done;
         rdData <= next_rdData;
         wdata <= next_wdata;
         writeCycle <= next_writeCycle;
      end
   end

   assign laneSelect_n = sel;
   assign laneWriteStrobe_n = wrs;
   assign outputGate_n = gate;
   assign flashReset_n = rst;
   assign dataOut = wdata;
   assign dataOe = oe;
   assign cmd.busy = (state != S_IDLE);
   assign cmd.done = done;
   assign cmd.rdData = rdData;
endmodule : flash_pin_sequencer

// ### design/flash_pins_if.sv
/*
 Carrier between the controller and its pin sequencer.
 Assumes both ends share mclk.
*/
`timescale 1ns/1ns
interface flash_pins_if;
   logic start;
   logic isWrite;
   logic isReset;
   logic [3:0] laneMask;
   logic [31:0] wrData;
   logic [7:0] holdCycles;
   logic busy;
   logic done;
   logic [31:0] rdData;
   modport ctrl (output start, output isWrite, output isReset, output laneMask, output wrData,
                 output holdCycles, input busy, input done, input rdData);
   modport seq (input start, input isWrite, input isReset, input laneMask, input wrData,
                input holdCycles, output busy, output done, output rdData);
endinterface : flash_pins_if

// ### tb/flash_array_model.sv
/* Behavioural four-lane flash array with per-lane autoselect.
   Assumes address and write data stay put until the strobes rise. */
`timescale 1ns/1ns
module flash_array_model #(
   parameter logic [7:0] ID_CODE = 8'h5C // Arbitrary identifier value.
) (
   input wire logic [20:0] addr,
   input wire logic [3:0] sel_n,
   input wire logic [3:0] wrs_n,
   input wire logic gate_n,
   input wire logic rst_n,
   input wire logic [31:0] din,
   output logic [31:0] dq
);
   logic [31:0] mem [16];
   logic [3:0] autoSel;
   logic [3:0] prevW;
   logic [31:0] word;
   initial begin
      for (int k = 0; k < 16; k++) mem[k] = 32'h40302010 + {4{k[7:0]}};
      autoSel = 4'h0;
      prevW = 4'hF;
   end
   always @(negedge rst_n) autoSel = 4'h0;
   always @(wrs_n) begin
      if (rst_n === 1'b1 && wrs_n == 4'hF) begin
         for (int i = 0; i < 4; i++) begin
            if (!prevW[i]) begin
               case (din[8*i+:8])
                  8'h90: autoSel[i] = 1'b1;
                  8'hF0: autoSel[i] = 1'b0;
                  8'h30: begin
                     // A sector is the four words sharing address bits 3:2. The erase finishes
                     // even though the controller deselects the lanes right after the command.
                     for (int k = 0; k < 16; k++) begin
                        if (k[3:2] == addr[3:2]) mem[k][8*i+:8] = 8'hFF;
                     end
                  end
                  default: mem[addr[3:0]][8*i+:8] = din[8*i+:8];
               endcase
            end
         end
      end
      prevW = wrs_n;
   end
   // A lane that is not driven shows the inverse, so stale data never passes.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         word[8*i+:8] = autoSel[i] ? ID_CODE : mem[addr[3:0]][8*i+:8];
         // A deselected lane stands by; after selection valid data needs the full access delay.
         if (gate_n || sel_n[i] || !rst_n) word[8*i+:8] = ~word[8*i+:8];
      end
   end
   assign #100 dq = word;
endmodule : flash_array_model

// ### tb/flash_bus_checker.sv
/* Pin-timing assertions for the flash bus controller.
   Assumes default timing parameters: reads hold 3 cycles, writes 2. */
`timescale 1ns/1ns
module flash_bus_checker (
   input wire logic mclk,
   input wire logic reset,
   input wire logic rspValid,
   input wire logic [3:0] byte_lane_select_n,
   input wire logic [3:0] byte_lane_write_strobe_n,
   input wire logic outputGate_n,
   input wire logic flashReset_n,
   input wire logic dataOe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   a_read_no_strobe: assert property (
      !outputGate_n |-> byte_lane_write_strobe_n == 4'hF) else $error("strobe low in read");
   a_read_access: assert property (
      $fell(outputGate_n) |=> !outputGate_n ##1 !outputGate_n ##1 outputGate_n) else $error("read length");
   a_read_answer: assert property (
      $fell(outputGate_n) |-> ##6 rspValid) else $error("read answer late");
   a_write_levels: assert property (
      byte_lane_write_strobe_n != 4'hF |-> outputGate_n && flashReset_n && dataOe
      && byte_lane_select_n == byte_lane_write_strobe_n) else $error("write levels");
   a_write_pulse: assert property (
      $rose(byte_lane_write_strobe_n != 4'hF) |=> $stable(byte_lane_write_strobe_n)
      ##1 byte_lane_write_strobe_n == 4'hF) else $error("write pulse length");
   a_reset_quiet: assert property (
      !flashReset_n |-> byte_lane_select_n == 4'hF && !dataOe) else $error("access in reset");
   c_read: cover property ($fell(outputGate_n));
   c_write: cover property ($rose(byte_lane_write_strobe_n == 4'h0));
   c_reset: cover property ($fell(flashReset_n));
endmodule : flash_bus_checker

bind flash_bus_controller flash_bus_checker chk (.mclk(mclk), .reset(reset), .rspValid(rspValid),
   .byte_lane_select_n(byte_lane_select_n), .byte_lane_write_strobe_n(byte_lane_write_strobe_n),
   .outputGate_n(outputGate_n), .flashReset_n(flashReset_n), .dataOe(dataOe));

// ### tb/tb.sv
/* Self-checking bench for the flash bus controller.
   Assumes default timing: read answer 7, write 6, reset 17 cycles. */
`timescale 1ns/1ns
module tb;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic reqValid = 1'b0;
   logic reqWrite = 1'b0;
   logic reqReset = 1'b0;
   logic [20:0] reqAddr = '0;
   logic [3:0] reqLanes = '0;
   logic [31:0] reqData = '0;
   logic reqReady, rspValid, outputGate_n, flashReset_n, dataOe;
   logic [31:0] rspData, dataOut, dataIn;
   logic [20:0] flashAddr;
   logic [3:0] selN, wrsN;
   int error_cnt = 0;
   int n_checks = 0;
   logic [31:0] q;
   localparam logic [7:0] ID = 8'h5C; // Arbitrary identifier value.
   always #20 mclk = ~mclk;
   flash_bus_controller DUT (.mclk(mclk), .reset(reset), .reqValid(reqValid), .reqWrite(reqWrite),
      .reqReset(reqReset), .reqAddr(reqAddr), .reqLanes(reqLanes), .reqData(reqData),
      .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .flashAddr(flashAddr),
      .byte_lane_select_n(selN), .byte_lane_write_strobe_n(wrsN), .outputGate_n(outputGate_n),
      .flashReset_n(flashReset_n), .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));
   flash_array_model #(.ID_CODE(ID)) flash (.addr(flashAddr), .sel_n(selN), .wrs_n(wrsN),
      .gate_n(outputGate_n), .rst_n(flashReset_n), .din(dataOut), .dq(dataIn));
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic req(input logic w, input logic r, input logic [20:0] a, input logic [3:0] ln,
         input logic [31:0] d, input int lat);
      int n;
      n = 0;
      @(posedge mclk);
      reqValid <= 1'b1;
      reqWrite <= w;
      reqReset <= r;
      reqAddr <= a;
      reqLanes <= ln;
      reqData <= d;
      do @(negedge mclk); while (reqReady !== 1'b1);
      @(posedge mclk);
      reqValid <= 1'b0;
      do begin
         @(negedge mclk);
         n++;
      end while (rspValid !== 1'b1 && n < 40);
      q = rspData;
      check("latency", 32'(lat), 32'(n));
   endtask : req
   task automatic t_boot_read;
      for (int i = 0; i < 4; i++) begin
         req(1'b0, 1'b0, 21'h3, 4'h1 << i, 32'h0, 7);
         check("lane", 32'h43332313 & (32'hFF << 8 * i), q);
      end
      // Idle with the address held so the flash can drop into sleep, then read the whole word.
      repeat (20) @(posedge mclk);
      check("held address", 32'h00000003, 32'(flashAddr));
      req(1'b0, 1'b0, 21'h3, 4'hF, 32'h0, 7);
      check("after sleep", 32'h43332313, q);
      $display("boot read done");
   endtask : t_boot_read
   task automatic t_write_read;
      req(1'b1, 1'b0, 21'h5, 4'h5, 32'hA1B2C3D4, 6);
      req(1'b0, 1'b0, 21'h5, 4'hF, 32'h0, 7);
      check("merged word", 32'h45B225D4, q);
      req(1'b1, 1'b0, 21'h9, 4'h8, 32'h30000000, 6);
      req(1'b0, 1'b0, 21'hB, 4'hF, 32'h0, 7);
      check("erased lane", 32'hFF3B2B1B, q);
      $display("write read done");
   endtask : t_write_read
   task automatic t_autoselect;
      req(1'b1, 1'b0, 21'h0, 4'hF, 32'h90909090, 6);
      req(1'b0, 1'b0, 21'h7, 4'hF, 32'h0, 7);
      check("ident", {4{ID}}, q);
      req(1'b1, 1'b0, 21'h0, 4'hF, 32'hF0F0F0F0, 6);
      req(1'b0, 1'b0, 21'h7, 4'hF, 32'h0, 7);
      check("array", 32'h47372717, q);
      $display("autoselect done");
   endtask : t_autoselect
   task automatic t_flash_reset;
      req(1'b1, 1'b0, 21'h0, 4'hF, 32'h90909090, 6);
      req(1'b1, 1'b1, 21'h0, 4'hF, 32'h0, 17);
      req(1'b0, 1'b0, 21'h2, 4'hF, 32'h0, 7);
      check("after reset", 32'h42322212, q);
      $display("flash reset done");
   endtask : t_flash_reset
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test
   initial begin
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      t_boot_read();
      t_write_read();
      t_autoselect();
      t_flash_reset();
      stop_test();
   end
   // A hung handshake would otherwise never end the run.
   initial begin
      #40000;
      error_cnt++;
      stop_test();
   end
endmodule : tb
